// [logic/rtcr_params.svh]
// rtcr_params.svh: offsets, field positions, reset values and constants
// assumes: included by the rtc event/calendar register bank and its package users
`ifndef RTCR_PARAMS_SVH
`define RTCR_PARAMS_SVH

// register byte offsets
`define RTCR_OFS_EVENT_ENABLE 8'h48
`define RTCR_OFS_EVENT_DISABLE 8'h4c
`define RTCR_OFS_EVENT_MASK 8'h50
`define RTCR_OFS_CALENDAR 8'h54
`define RTCR_OFS_TUNER 8'h44
`define RTCR_OFS_INTERVAL0 8'h30
`define RTCR_OFS_INTERVAL1 8'h34
`define RTCR_OFS_BUSY_CTRL 8'h60
`define RTCR_OFS_IRQ_STATUS 8'h64
`define RTCR_OFS_IRQ_MASK 8'h68
`define RTCR_OFS_BUILD_PARAMS 8'hf0
`define RTCR_OFS_REVISION 8'hfc

// event bit positions
`define RTCR_BIT_WRAP 0
`define RTCR_BIT_MATCH0 8
`define RTCR_BIT_MATCH1 9
`define RTCR_BIT_INTERVAL0 16
`define RTCR_BIT_INTERVAL1 17
`define RTCR_EVENT_BITS 32'h0003_0301

// calendar fields
`define RTCR_CAL_YEAR_LSB 26
`define RTCR_CAL_MONTH_LSB 22
`define RTCR_CAL_DAY_LSB 17
`define RTCR_CAL_HOUR_LSB 12
`define RTCR_CAL_MIN_LSB 6
`define RTCR_CAL_SEC_LSB 0
`define RTCR_HOUR_MAX 5'h17
`define RTCR_MINSEC_MAX 6'h3b
`define RTCR_MONTH_MAX 4'hc

// reset values
`define RTCR_RST_MASK 32'h0000_0000
`define RTCR_RST_CAL 32'h0000_0000
`define RTCR_RST_LEAP 1'h1

// build configuration (constants fixed at build time)
`define RTCR_CFG_TUNER_PRESENT 1'h1
`define RTCR_CFG_POWER_WRITABLE 1'h0
`define RTCR_CFG_POWER_FIXED 3'h2
`define RTCR_CFG_MATCH_COUNT 2'h1
`define RTCR_CFG_INTERVAL_COUNT 1'h0
`define RTCR_CFG_I0_WRITABLE 1'h1
`define RTCR_CFG_I1_WRITABLE 1'h0
`define RTCR_CFG_I0_FIXED 5'h0f
`define RTCR_CFG_I1_FIXED 5'h0f

// revision fields; values are arbitrary
`define RTCR_REV_NUMBER 12'h001
`define RTCR_REV_VARIANT 4'h0

`endif

// [logic/rtcr_pkg.sv]
// rtcr_pkg.sv: types of the rtc event/calendar register bank
// assumes: used by name only, never imported
package rtcr_pkg;
	// bus slave data-phase states
	typedef enum logic [1:0] {
		RTCR_IDLE = 2'b01,
		RTCR_DATA = 2'b10
	} rtcr_phase_t;
endpackage : rtcr_pkg

// [logic/rtcr_regs.sv]
// rtcr_regs.sv: event gate, calendar word, build and revision registers
// assumes: one ahb-lite master, single word transfers, counter core outside
//
// Notes on behaviour
// - disable port ones clear gate bits
// - enable port ones set gate bits
// - gate passes events; resets to zero
// - event bits at 0, 8, 9, 16, 17
// - busy drops gated writes; calendar, tuner and interval reads zero
// - year upper field; leap when low bits zero
// - month bits 25:22, day from one
// - hour 24-hour format, 0 to 23
// - minute and second 0 to 59
// - build bit 0 reports tuner present
// - fixed tuner power ignores power writes
// - match count field encodes 0..2
// - interval count bit: 0 one, 1 two
// - fixed interval tap ignores tap writes
// - revision number and variant, no effect
`timescale 1ns/1ps
`include "rtcr_params.svh"
`default_nettype none

module rtcr_regs (
	input wire logic clk_sys,
	input wire logic arst_n,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// raw events from the counter core, same clock
	input wire logic [31:0] event_raw,
	// gated peripheral events
	output logic [31:0] event_out,
	// calendar word and tuner/interval settings toward the core
	output logic [31:0] calendar_word,
	output logic [2:0] tuner_power_field,
	output logic [4:0] interval0_tap,
	output logic [4:0] interval1_tap,
	output logic leap_year,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////
	// helpers
	// the calendar check is shared by the write path; keeping it in one
	// function means the refuse rule and the range checks cannot drift apart

	// true when a calendar word has legal time, month and day fields
	function automatic logic cal_ok(input logic [31:0] w);
		cal_ok = (w[16:12] <= `RTCR_HOUR_MAX)
			&& (w[11:6] <= `RTCR_MINSEC_MAX)
			&& (w[5:0] <= `RTCR_MINSEC_MAX)
			&& (w[25:22] != 4'h0) && (w[25:22] <= `RTCR_MONTH_MAX)
			&& (w[21:17] != 5'h00);
	endfunction : cal_ok

	////////////////////////////////////////////////////////////////////////
	// constant read words
	// build and revision words are wired constants: nothing in the block
	// writes them, so they cost no flops and cannot be disturbed by software

	logic [31:0] build_word; // build parameters
	logic [31:0] rev_word; // module revision
	// constants only, so writes can never change them
	assign build_word = {3'h0, `RTCR_CFG_I1_FIXED, 3'h0, `RTCR_CFG_I0_FIXED,
		`RTCR_CFG_I1_WRITABLE, `RTCR_CFG_I0_WRITABLE, 1'h0,
		`RTCR_CFG_INTERVAL_COUNT, 2'h0, `RTCR_CFG_MATCH_COUNT,
		1'h0, `RTCR_CFG_POWER_FIXED, 2'h0, `RTCR_CFG_POWER_WRITABLE,
		`RTCR_CFG_TUNER_PRESENT};
	// read back only, feeds no logic
	assign rev_word = {12'h000, `RTCR_REV_VARIANT, 4'h0, `RTCR_REV_NUMBER};

	////////////////////////////////////////////////////////////////////////
	// bus address phase capture
	// the slave never stretches a transfer: hreadyout stays high, so an
	// address phase taken on one edge has its data phase on the next
	// only the low byte of the address is decoded; the upper bits alias
	// hsize is not checked, every access is treated as a whole word

	rtcr_pkg::rtcr_phase_t phase_q, phase_d; // data phase pending
	logic [7:0] addr_q, addr_d; // latched offset
	logic wr_q, wr_d; // latched direction
	logic take; // address phase accepted

	assign take = hsel && hready && htrans[1];

	// next phase state; a data phase always finishes in one cycle
	always_comb begin
		addr_d = addr_q;
		wr_d = wr_q;
		phase_d = rtcr_pkg::RTCR_IDLE;
		if (take) begin
			addr_d = haddr[7:0];
			wr_d = hwrite;
			phase_d = rtcr_pkg::RTCR_DATA;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			phase_q <= rtcr_pkg::RTCR_IDLE;
			addr_q <= 8'h00;
			wr_q <= 1'b0;
		end else begin
			phase_q <= phase_d;
			addr_q <= addr_d;
			wr_q <= wr_d;
		end
	end

	logic wr_en; // write data valid this cycle
	logic rd_en; // address phase is a read
	assign wr_en = (phase_q == rtcr_pkg::RTCR_DATA) && wr_q;
	assign rd_en = take && !hwrite;

	////////////////////////////////////////////////////////////////////////
	// register state
	// busy stands in for the core's own busy; software sets it here so the
	// drop-and-read-zero path can be exercised without the counter core
	// the gated registers keep their value while busy, the write is lost

	logic [31:0] gate_q, gate_d; // event gate bits
	logic [31:0] cal_q, cal_d; // calendar word
	logic [2:0] power_q, power_d; // tuner power
	logic [4:0] tap0_q, tap0_d; // interval 0 tap
	logic [4:0] tap1_q, tap1_d; // interval 1 tap
	logic busy_q, busy_d; // busy flag, software driven here
	logic [31:0] ist_q, ist_d; // interrupt status, sticky
	logic [31:0] imask_q, imask_d; // interrupt mask
	logic busy_wr; // write dropped while busy
	logic cal_bad; // calendar write refused as illegal

	// register next values
	always_comb begin
		gate_d = gate_q;
		cal_d = cal_q;
		power_d = power_q;
		tap0_d = tap0_q;
		tap1_d = tap1_q;
		busy_d = busy_q;
		imask_d = imask_q;
		busy_wr = 1'b0;
		cal_bad = 1'b0;
		ist_d = ist_q;
		if (wr_en) begin
			unique case (addr_q)
				`RTCR_OFS_EVENT_ENABLE: begin
					if (busy_q) busy_wr = 1'b1;
					else gate_d = gate_q | (hwdata & `RTCR_EVENT_BITS);
				end
				`RTCR_OFS_EVENT_DISABLE: begin
					if (busy_q) busy_wr = 1'b1;
					else gate_d = gate_q & ~(hwdata & `RTCR_EVENT_BITS);
				end
				`RTCR_OFS_CALENDAR: begin
					if (busy_q) busy_wr = 1'b1;
					else if (cal_ok(hwdata)) cal_d = hwdata;
					else cal_bad = 1'b1; // illegal time, month or day fields are refused
				end
				`RTCR_OFS_TUNER: begin
					// fixed power keeps the build value
					if (busy_q) busy_wr = 1'b1;
					else if (`RTCR_CFG_POWER_WRITABLE) power_d = hwdata[2:0];
				end
				`RTCR_OFS_INTERVAL0: begin
					if (busy_q) busy_wr = 1'b1;
					else if (`RTCR_CFG_I0_WRITABLE) tap0_d = hwdata[4:0];
				end
				`RTCR_OFS_INTERVAL1: begin
					if (busy_q) busy_wr = 1'b1;
					else if (`RTCR_CFG_I1_WRITABLE) tap1_d = hwdata[4:0];
				end
				`RTCR_OFS_BUSY_CTRL: busy_d = hwdata[0];
				`RTCR_OFS_IRQ_STATUS: ist_d = ist_q & ~hwdata;
				`RTCR_OFS_IRQ_MASK: imask_d = hwdata & 32'h0000_0003;
				default: ; // read-only or unmapped, no effect
			endcase
		end
		// set wins over a clear in the same cycle
		ist_d[0] = ist_d[0] | busy_wr;
		ist_d[1] = ist_d[1] | cal_bad;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			gate_q <= `RTCR_RST_MASK;
			cal_q <= `RTCR_RST_CAL;
			power_q <= `RTCR_CFG_POWER_FIXED;
			tap0_q <= `RTCR_CFG_I0_FIXED;
			tap1_q <= `RTCR_CFG_I1_FIXED;
			busy_q <= 1'b0;
			ist_q <= 32'h0000_0000;
			imask_q <= 32'h0000_0000;
		end else begin
			gate_q <= gate_d;
			cal_q <= cal_d;
			power_q <= power_d;
			tap0_q <= tap0_d;
			tap1_q <= tap1_d;
			busy_q <= busy_d;
			ist_q <= ist_d;
			imask_q <= imask_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read mux, registered at the address phase
	// hrdata is zero outside a read data phase, so a stale word never lingers
	// the event gate read is not hidden by busy, only the gated registers are

	logic [31:0] rdata_d; // next read word

	// busy hides the gated registers; write-only ports read zero
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (rd_en) begin
			unique case (haddr[7:0])
				`RTCR_OFS_EVENT_MASK: rdata_d = gate_q;
				`RTCR_OFS_CALENDAR: rdata_d = busy_q ? 32'h0000_0000 : cal_q;
				`RTCR_OFS_TUNER: rdata_d = busy_q ? 32'h0000_0000 : {29'h0, power_q};
				`RTCR_OFS_INTERVAL0: rdata_d = busy_q ? 32'h0000_0000 : {27'h0, tap0_q};
				`RTCR_OFS_INTERVAL1: rdata_d = busy_q ? 32'h0000_0000 : {27'h0, tap1_q};
				`RTCR_OFS_BUSY_CTRL: rdata_d = {31'h0, busy_q};
				`RTCR_OFS_IRQ_STATUS: rdata_d = ist_q;
				`RTCR_OFS_IRQ_MASK: rdata_d = imask_q;
				`RTCR_OFS_BUILD_PARAMS: rdata_d = build_word;
				`RTCR_OFS_REVISION: rdata_d = rev_word;
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// output registers
	// every output comes from a flop; settings toward the core use the next
	// values so, from the first clock after reset, they line up with the registers rather than lag a cycle more
	// leap_year resets to one because the reset calendar word has year zero

	logic [31:0] evout_d; // gated events
	logic irq_d; // interrupt level
	assign evout_d = event_raw & gate_q & `RTCR_EVENT_BITS;
	assign irq_d = |(ist_d & imask_q);

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			hrdata <= 32'h0000_0000;
			event_out <= 32'h0000_0000;
			calendar_word <= 32'h0000_0000;
			tuner_power_field <= 3'h0;
			interval0_tap <= 5'h00;
			interval1_tap <= 5'h00;
			leap_year <= `RTCR_RST_LEAP; // year zero is a leap year
			irq <= 1'b0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hrdata <= rdata_d;
			event_out <= evout_d;
			calendar_word <= cal_d;
			tuner_power_field <= power_d;
			interval0_tap <= tap0_d;
			interval1_tap <= tap1_d;
			leap_year <= (cal_d[27:26] == 2'h0);
			irq <= irq_d;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// assertions
	// all properties sample on the system clock and are off during reset
	// the named sequences pick out accepted gate writes for the gate checks

	sequence dis_write_s;
		wr_en && !busy_q && addr_q == `RTCR_OFS_EVENT_DISABLE;
	endsequence

	sequence en_write_s;
		wr_en && !busy_q && addr_q == `RTCR_OFS_EVENT_ENABLE;
	endsequence

	disable_clear_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		dis_write_s |=> ((gate_q & $past(hwdata & `RTCR_EVENT_BITS)) == 32'h0
			&& (gate_q | $past(hwdata)) == ($past(gate_q) | $past(hwdata))))
		else $error("disable write did not clear gate bits");

	enable_set_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		en_write_s |=> (gate_q == ($past(gate_q) | $past(hwdata & `RTCR_EVENT_BITS))))
		else $error("enable write did not set gate bits");

	event_gate_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		##1 event_out == ($past(event_raw) & $past(gate_q)))
		else $error("event output not gated by mask");

	gate_layout_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(gate_q & ~`RTCR_EVENT_BITS) == 32'h0)
		else $error("gate bit outside event positions");

	busy_drop_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(wr_en && busy_q) |=> ($stable(gate_q) && $stable(cal_q)))
		else $error("write accepted while busy");

	busy_read_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(rd_en && busy_q && haddr[7:0] == `RTCR_OFS_CALENDAR) |=> hrdata == 32'h0)
		else $error("calendar read not zero while busy");

	leap_flag_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		##1 leap_year == (cal_q[27:26] == 2'h0))
		else $error("leap flag wrong");

	cal_fields_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		cal_q[16:12] <= `RTCR_HOUR_MAX && cal_q[11:6] <= `RTCR_MINSEC_MAX
			&& cal_q[5:0] <= `RTCR_MINSEC_MAX)
		else $error("calendar time field out of range");

	power_fixed_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		power_q == `RTCR_CFG_POWER_FIXED)
		else $error("fixed tuner power changed");

	tap1_fixed_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		tap1_q == `RTCR_CFG_I1_FIXED)
		else $error("fixed interval tap changed");

	build_read_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(rd_en && haddr[7:0] == `RTCR_OFS_BUILD_PARAMS) |=> hrdata == 32'h0f0f_4121)
		else $error("build parameters read wrong");

	// mask reads return the gate bits that stood at the address phase
	// gate bits are never hidden by busy
	mask_read_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(rd_en && haddr[7:0] == `RTCR_OFS_EVENT_MASK) |=> hrdata == $past(gate_q))
		else $error("event mask read wrong");

	// a writable interval tap takes what software wrote
	// the fixed tap is covered by tap1_fixed_a above
	tap0_write_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(wr_en && !busy_q && addr_q == `RTCR_OFS_INTERVAL0)
			|=> tap0_q == $past(hwdata[4:0]))
		else $error("writable interval tap not taken");

	// revision word is a build constant whatever was written before
	// variant zero, number one
	revision_read_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(rd_en && haddr[7:0] == `RTCR_OFS_REVISION) |=> hrdata == 32'h0000_0001)
		else $error("revision read wrong");

	// once set, the calendar word always holds a legal month and day
	// the all-zero reset word is the only exception
	month_range_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		cal_q != 32'h0 |-> (cal_q[25:22] >= 4'h1 && cal_q[25:22] <= 4'hc
			&& cal_q[21:17] != 5'h00))
		else $error("calendar month or day out of range");

	// a calendar write dropped while busy must leave its sticky status bit
	// so software can learn that the write was lost
	busy_status_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(wr_en && busy_q && addr_q == `RTCR_OFS_CALENDAR) |=> ist_q[0])
		else $error("dropped write not flagged");

	// one match unit and one interval unit are reported
	// count fields are read from the build word on every read of it
	match_count_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(rd_en && haddr[7:0] == `RTCR_OFS_BUILD_PARAMS)
			|=> (hrdata[9:8] == 2'h1 && hrdata[12] == 1'b0))
		else $error("unit count fields wrong");

endmodule : rtcr_regs

`default_nettype wire

// [tb/rtcr_regs_tb_top.sv]
// rtcr_regs_tb_top.sv: self-checking bench for the event gate and calendar register bank
// assumes: rtcr_params.svh on the include path, single ahb-lite master played by this bench
`timescale 1ns/1ps
`include "rtcr_params.svh"
`default_nettype none

module rtcr_regs_tb_top;
	////////////////////////////////////////////////////////////////////////////////
	logic clk_sys = 1'b0; // 10 mhz system clock
	logic arst_n = 1'b0; // async reset, low active
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2; // whole words only
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] event_raw = 32'hffff_ffff; // every raw event firing, gate decides
	logic [31:0] hrdata, event_out, calendar_word;
	logic hreadyout, hresp, leap_year, irq;
	logic [2:0] tuner_power_field;
	logic [4:0] interval0_tap, interval1_tap;
	int error_cnt = 0;
	int tests_run = 0;
	int cyc = 0; // timeout counter
	logic [31:0] rd;

	// clock: invert each half period
	always #50 clk_sys = ~clk_sys;

	rtcr_regs uut (.clk_sys(clk_sys), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .event_raw(event_raw),
		.event_out(event_out), .calendar_word(calendar_word),
		.tuner_power_field(tuner_power_field), .interval0_tap(interval0_tap),
		.interval1_tap(interval1_tap), .leap_year(leap_year), .irq(irq));

	////////////////////////////////////////////////////////////////////////////////
	// compare, counting every call
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// one single transfer; waits on hready, no fixed latency assumed
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge clk_sys);
		while (hreadyout !== 1'b1) @(posedge clk_sys);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk_sys);
		while (hreadyout !== 1'b1) @(posedge clk_sys);
		rd = hrdata; // taken at the edge ending the data phase
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask : xfer

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr

	task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask : rchk

	// calendar word from fields, widths 6/4/5/5/6/6
	function automatic logic [31:0] cal(input int y, input int mo, input int d, input int h,
		input int mi, input int s);
		return {y[5:0], mo[3:0], d[4:0], h[4:0], mi[5:0], s[5:0]};
	endfunction : cal

	////////////////////////////////////////////////////////////////////////////////
	// reset values of gate, calendar, an unmapped read, event output and irq
	task automatic t_reset();
		rchk("gate_rst", 32'h50, 32'h0);
		rchk("cal_rst", 32'h54, 32'h0);
		rchk("unmapped", 32'h80, 32'h0);
		chk("event_out_rst", 32'h0, event_out);
		chk("irq_rst", 32'h0, {31'h0, irq});
	endtask : t_reset

	// enable, disable, zero writes and the gate itself
	task automatic t_events();
		wr(32'h48, 32'hffff_ffff);
		rchk("gate_all", 32'h50, 32'h0003_0301);
		chk("event_out_all", 32'h0003_0301, event_out);
		wr(32'h4c, 32'h0000_0100);
		rchk("gate_dis8", 32'h50, 32'h0003_0201);
		wr(32'h4c, 32'h0);
		rchk("gate_zero", 32'h50, 32'h0003_0201);
		chk("event_out_dis", 32'h0003_0201, event_out);
		wr(32'h4c, 32'h0003_0201);
		rchk("gate_none", 32'h50, 32'h0);
		chk("event_out_none", 32'h0, event_out);
		wr(32'h48, 32'h0001_0001);
		rchk("gate_some", 32'h50, 32'h0001_0001);
		event_raw <= 32'h0000_0301;
		repeat (2) @(posedge clk_sys);
		chk("event_out_raw", 32'h0000_0001, event_out);
		event_raw <= 32'hffff_ffff;
	endtask : t_events

	// legal boundaries kept, illegal fields dropped
	task automatic t_calendar();
		logic [31:0] bad [6];
		bad = '{cal(5, 1, 1, 24, 0, 0), cal(5, 1, 1, 0, 60, 0), cal(5, 1, 1, 0, 0, 60),
			cal(5, 13, 1, 0, 0, 0), cal(5, 0, 1, 0, 0, 0), cal(5, 1, 0, 0, 0, 0)};
		wr(32'h54, cal(4, 2, 29, 23, 59, 59));
		rchk("cal_leap", 32'h54, cal(4, 2, 29, 23, 59, 59));
		chk("cal_out", cal(4, 2, 29, 23, 59, 59), calendar_word);
		chk("leap_on", 32'h1, {31'h0, leap_year});
		wr(32'h54, cal(5, 12, 31, 0, 0, 0));
		rchk("cal_dec", 32'h54, cal(5, 12, 31, 0, 0, 0));
		chk("leap_off", 32'h0, {31'h0, leap_year});
		foreach (bad[i]) begin
			wr(32'h54, bad[i]);
			rchk("cal_bad", 32'h54, cal(5, 12, 31, 0, 0, 0));
		end
		rchk("stat_bad", 32'h64, 32'h2);
		wr(32'h64, 32'h2);
	endtask : t_calendar

	// busy drops gate and calendar writes and hides the calendar read; status and irq path
	task automatic t_busy();
		wr(32'h60, 32'h1);
		wr(32'h4c, 32'h0001_0001);
		wr(32'h54, cal(7, 3, 3, 3, 3, 3));
		rchk("cal_busy", 32'h54, 32'h0);
		rchk("gate_busy", 32'h50, 32'h0001_0001);
		rchk("stat_busy", 32'h64, 32'h1);
		chk("irq_masked", 32'h0, {31'h0, irq});
		wr(32'h68, 32'h1);
		repeat (2) @(posedge clk_sys);
		chk("irq_on", 32'h1, {31'h0, irq});
		wr(32'h64, 32'h1);
		repeat (2) @(posedge clk_sys);
		chk("irq_clr", 32'h0, {31'h0, irq});
		wr(32'h60, 32'h0);
		rchk("cal_kept", 32'h54, cal(5, 12, 31, 0, 0, 0));
	endtask : t_busy

	// constant build and revision words, fixed tuner power and tap1, writable tap0
	task automatic t_build();
		logic [31:0] bexp;
		bexp = {16'h0, `RTCR_CFG_I1_WRITABLE, `RTCR_CFG_I0_WRITABLE, 1'b0,
			`RTCR_CFG_INTERVAL_COUNT, 2'b0, `RTCR_CFG_MATCH_COUNT, 7'h0, `RTCR_CFG_TUNER_PRESENT};
		wr(32'hf0, 32'h0);
		wr(32'hfc, 32'hffff_ffff);
		xfer(1'b0, 32'hf0, 32'h0);
		chk("build", bexp, rd & 32'h0000_d301);
		rchk("revision", 32'hfc, {12'h0, `RTCR_REV_VARIANT, 4'h0, `RTCR_REV_NUMBER});
		wr(32'h44, 32'h5);
		wr(32'h30, 32'h3);
		wr(32'h34, 32'h3);
		repeat (2) @(posedge clk_sys);
		chk("power", {29'h0, `RTCR_CFG_POWER_FIXED}, {29'h0, tuner_power_field});
		chk("tap0", 32'h3, {27'h0, interval0_tap});
		chk("tap1", {27'h0, `RTCR_CFG_I1_FIXED}, {27'h0, interval1_tap});
	endtask : t_build

	////////////////////////////////////////////////////////////////////////////////
	// verdict and end of run
	task automatic tally_and_finish();
		$display("checks run %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : tally_and_finish

	// hang guard, far above the roughly 160 cycles the run needs
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			tally_and_finish();
		end
	end

	// main sequence
	initial begin
		repeat (5) @(posedge clk_sys);
		arst_n <= 1'b1;
		t_reset();
		t_events();
		t_calendar();
		t_busy();
		t_build();
		tally_and_finish();
	end
endmodule : rtcr_regs_tb_top

`default_nettype wire
